// ### design/bus_buffer_consts.svh
// constants for the board bus buffer and wait-state control block
// assumes a 100 MHz mclk and a phase generator local to this block
`ifndef BUS_BUFFER_CONSTS_SVH
`define BUS_BUFFER_CONSTS_SVH

// processor clock period and one wait state, in ns
`define PROC_CLK_NS        333
`define WAIT_STATE_NS      333
`define MCLK_NS            10
// mclk cycles per processor clock phase: four phases per processor clock
`define PHASE_CYCLES       ((`PROC_CLK_NS / 4) / `MCLK_NS)
`define PHASE_CNT_W        4
`define PHASE_CNT_RST      4'h0
// memory windows at 3 MHz, in ns
`define READ_ACCESS_NS     490
`define WRITE_CAPTURE_NS   600
// on-board bit-I/O space: upper four address bits equal to this value
`define IO_ONBOARD_UPPER   4'h0

`endif

// ### design/bus_buffer_pkg.sv
// types for the board bus buffer and wait-state control block
// assumes the consts header is included by phase_gen and bus_buffer_ctrl
`default_nettype none
package bus_buffer_pkg;

  typedef enum logic [3:0] {
    PH1 = 4'h1,
    PH2 = 4'h2,
    PH3 = 4'h4,
    PH4 = 4'h8
  } phase_type;

  typedef enum logic [3:0] {
    CYC_IDLE  = 4'h1,
    CYC_SAMPLE = 4'h2,
    CYC_WAIT  = 4'h4,
    CYC_FINAL = 4'h8
  } cycle_type;

endpackage : bus_buffer_pkg
`default_nettype wire

// ### design/phase_if.sv
// carries the processor clock phase strobes between the phase generator and the top
// assumes one mclk domain
`timescale 1ns/1ps
`default_nettype none
interface phase_if;
  logic ph1_lead;
  logic ph3_lead;
  logic [3:0] phase;
  modport gen  (output ph1_lead, output ph3_lead, output phase);
  modport user (input ph1_lead, input ph3_lead, input phase);
endinterface : phase_if
`default_nettype wire

// ### design/phase_gen.sv
// four-phase processor clock generator derived from mclk
// assumes synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "bus_buffer_consts.svh"
module phase_gen
  import bus_buffer_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  phase_if.gen      ph
);
  typedef struct packed {
    logic [`PHASE_CNT_W-1:0] cnt;
    phase_type               phase;
  } state_type;

  state_type st_reg;
  state_type st_next;

  always_comb begin
    st_next = st_reg;
    if (st_reg.cnt == `PHASE_CNT_W'(`PHASE_CYCLES - 1)) begin
      st_next.cnt = `PHASE_CNT_RST;
      case (st_reg.phase)
        PH1:     st_next.phase = PH2;
        PH2:     st_next.phase = PH3;
        PH3:     st_next.phase = PH4;
        PH4:     st_next.phase = PH1;
        default: st_next.phase = PH1;
      endcase
    end else begin
      st_next.cnt = st_reg.cnt + `PHASE_CNT_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '{cnt: `PHASE_CNT_RST, phase: PH4};
    end else begin
      st_reg <= st_next;
    end
  end

  // leading edge: first mclk cycle of a phase
  assign ph.ph1_lead = (st_reg.phase == PH1) && (st_reg.cnt == `PHASE_CNT_RST);
  assign ph.ph3_lead = (st_reg.phase == PH3) && (st_reg.cnt == `PHASE_CNT_RST);
  assign ph.phase    = st_reg.phase;
endmodule : phase_gen
`default_nettype wire

// ### design/bus_buffer_ctrl.sv
// memory cycle wait-state control, cycle delimiter and bus buffer steering
// assumes all inputs synchronous to mclk; phases made locally from mclk
`timescale 1ns/1ps
`default_nettype none
`include "bus_buffer_consts.svh"

// How it works
// - ready sampled on phase one after strobe
// - read data captured next phase-one edge
// - write done at next phase-one edge
// - ready low: wait state, acknowledge high
// - ready high: drop acknowledge, resume
// - each wait holds lines one period
// - one more clock after ready high
// - jumper loops acknowledge into ready
// - acknowledge low at each cycle start
// - delimiter per cycle, phase three on
// - grant low, offboard mem: inverse of read
// - grant low, onboard mem: drive off
// - grant high, offboard mem: drive on
// - grant high, onboard: follow read
// - address buffers reverse under grant
// - onboard-sourced signals always driven out
// - bit-io buffers off for onboard io
// - memory strobes reverse under grant
// - grant only after cycle ends, lines floated
// - io select from upper address and strobe
module bus_buffer_ctrl
  import bus_buffer_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        mem_access_strobe_n,
  input  wire logic        read_strobe,
  input  wire logic        cycle_request,
  input  wire logic        mem_ready_in,
  input  wire logic        one_wait_jumper,
  input  wire logic        bus_request_n,
  input  wire logic        onboard_mem_select,
  input  wire logic [3:0]  addr_upper,
  input  wire logic [15:0] mem_data_in,
  output logic             wait_ack,
  output logic             cycle_delimiter_n,
  output logic             cycle_done,
  output logic [15:0]      read_data,
  output logic             read_data_valid,
  output logic             bus_grant,
  output logic             cpu_lines_float,
  output logic             data_dir_offboard,
  output logic             addr_dir_offboard,
  output logic             ctrl_dir_offboard,
  output logic             always_out_enable,
  output logic             internal_io_select,
  output logic             bit_io_buf_enable
);

  // ****************************************
  // phase strobes
  // ****************************************
  phase_if ph ();

  phase_gen u_phase (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ph    (ph.gen)
  );

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    cycle_type   cyc;
    logic        is_read;
    logic        wait_ack;
    logic        delim_n;
    logic        done;
    logic [15:0] rdata;
    logic        rvalid;
    logic        grant;
    logic        lines_float;
  } state_type;

  state_type st_reg;
  state_type st_next;

  logic ready_eff;

  // jumper fitted: acknowledge loops back as ready
  assign ready_eff = one_wait_jumper ? st_reg.wait_ack : mem_ready_in;

  always_comb begin
    st_next        = st_reg;
    st_next.done   = 1'b0;
    st_next.rvalid = 1'b0;
    case (st_reg.cyc)
      CYC_IDLE: begin
        // lines floated or granted: no new cycle until the request is withdrawn
        if (!st_reg.lines_float && cycle_request && !mem_access_strobe_n
            && ph.ph1_lead) begin
          st_next.cyc      = CYC_SAMPLE;
          st_next.is_read  = read_strobe;
          st_next.wait_ack = 1'b0;
        end
      end
      CYC_SAMPLE: begin
        if (ph.ph3_lead) begin
          st_next.delim_n = 1'b0;
        end
        // ready sampled on the next phase one
        if (ph.ph1_lead) begin
          if (ready_eff) begin
            st_next.cyc = CYC_FINAL;
          end else begin
            st_next.cyc      = CYC_WAIT;
            st_next.wait_ack = 1'b1;
          end
        end
      end
      CYC_WAIT: begin
        // no timeout: a slow memory may hold ready low indefinitely
        if (ph.ph1_lead && ready_eff) begin
          st_next.cyc      = CYC_FINAL;
          st_next.wait_ack = 1'b0;
        end
        // otherwise each pass holds lines one more period
      end
      CYC_FINAL: begin
        if (ph.ph1_lead) begin
          st_next.cyc     = CYC_IDLE;
          st_next.done    = 1'b1;
          st_next.delim_n = 1'b1;
          if (st_reg.is_read) begin
            st_next.rdata  = mem_data_in;
            st_next.rvalid = 1'b1;
          end
        end
      end
      default: begin
        st_next.cyc = CYC_IDLE;
      end
    endcase
    // grant changes only between cycles
    if (st_next.cyc == CYC_IDLE && st_reg.cyc == CYC_IDLE) begin
      st_next.lines_float = !bus_request_n;
      // grant one mclk cycle after the float, so the dma side never meets driven lines
      st_next.grant       = !bus_request_n && st_reg.lines_float;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '{cyc: CYC_IDLE, is_read: 1'b0, wait_ack: 1'b0, delim_n: 1'b1,
                  done: 1'b0, rdata: 16'h0000, rvalid: 1'b0, grant: 1'b0,
                  lines_float: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign wait_ack          = st_reg.wait_ack;
  assign cycle_delimiter_n = st_reg.delim_n;
  assign cycle_done        = st_reg.done;
  assign read_data         = st_reg.rdata;
  assign read_data_valid   = st_reg.rvalid;
  assign bus_grant         = st_reg.grant;
  assign cpu_lines_float   = st_reg.lines_float;

  // 1 = off-board, 0 = toward the board
  always_comb begin
    case ({st_reg.grant, onboard_mem_select})
      2'b00:   data_dir_offboard = !read_strobe;
      2'b01:   data_dir_offboard = 1'b1;
      2'b10:   data_dir_offboard = 1'b0;
      2'b11:   data_dir_offboard = read_strobe;
      default: data_dir_offboard = 1'b1;
    endcase
  end
  // no register in the path

  assign addr_dir_offboard = !st_reg.grant;
  assign ctrl_dir_offboard = !st_reg.grant;
  assign always_out_enable = 1'b1;

  // strobe high marks a bit-io access rather than memory
  assign internal_io_select = mem_access_strobe_n
                              && (addr_upper == `IO_ONBOARD_UPPER);
  assign bit_io_buf_enable  = !internal_io_select;

endmodule : bus_buffer_ctrl
`default_nettype wire

// ### tb/bus_buffer_properties.sv
// port checker for bus_buffer_ctrl
// assumes one mclk domain and a synchronous active-low rst_n
`timescale 1ns/1ps
`default_nettype none
`include "bus_buffer_consts.svh"
module bus_buffer_properties (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       mem_access_strobe_n,
  input wire logic       read_strobe,
  input wire logic       bus_request_n,
  input wire logic       onboard_mem_select,
  input wire logic [3:0] addr_upper,
  input wire logic       wait_ack,
  input wire logic       cycle_delimiter_n,
  input wire logic       cycle_done,
  input wire logic       bus_grant,
  input wire logic       cpu_lines_float,
  input wire logic       data_dir_offboard,
  input wire logic       addr_dir_offboard,
  input wire logic       ctrl_dir_offboard,
  input wire logic       always_out_enable,
  input wire logic       internal_io_select,
  input wire logic       bit_io_buf_enable
);
  // ****
  // port relations
  // ****
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_resume;
    ##32 cycle_done;
  endsequence
  a_data_dir: assert property (
    data_dir_offboard == (bus_grant ? onboard_mem_select & read_strobe
                                    : onboard_mem_select | !read_strobe))
    else $error("data direction wrong");
  a_dir_grant: assert property (
    addr_dir_offboard == !bus_grant && ctrl_dir_offboard == !bus_grant)
    else $error("address or control direction wrong");
  a_io_select: assert property (
    internal_io_select == (mem_access_strobe_n && addr_upper == `IO_ONBOARD_UPPER)
    && bit_io_buf_enable == !internal_io_select)
    else $error("bit io select wrong");
  a_out_fixed: assert property (always_out_enable && (!bus_grant || cpu_lines_float))
    else $error("fixed enable or float wrong");
  a_grant_gap: assert property (
    $rose(bus_grant) |-> cycle_delimiter_n && !$past(bus_request_n) && $past(cpu_lines_float))
    else $error("grant inside a cycle");
  a_float_lead: assert property ($rose(cpu_lines_float) |-> !bus_grant)
    else $error("grant not after float");
  a_wait_resume: assert property ($fell(wait_ack) |-> s_resume)
    else $error("cycle not done one clock after wait");
  a_wait_hold: assert property ($rose(wait_ack) |-> wait_ack[*8] ##24 wait_ack)
    else $error("wait state shorter than a clock");
  a_ack_start: assert property ($fell(cycle_delimiter_n) |-> !wait_ack)
    else $error("wait active at cycle start");
  a_done_delim: assert property (
    cycle_done |-> cycle_delimiter_n && !$past(cycle_delimiter_n))
    else $error("delimiter not ending with cycle");
endmodule : bus_buffer_properties
bind bus_buffer_ctrl bus_buffer_properties u_props (.*);
`default_nettype wire

// ### tb/mem_partner.sv
// slow memory on the far side of the bus
// assumes delimiter low marks an active cycle
`timescale 1ns/1ps
`default_nettype none
module mem_partner (
  input  wire logic        mclk,
  input  wire logic        cycle_delimiter_n,
  input  wire logic [3:0]  n_waits,
  output logic             mem_ready_in,
  output logic [15:0]      mem_data_in
);
  // ****
  // memory answer
  // ****
  int cnt = 0;
  always @(posedge mclk) begin
    cnt <= cycle_delimiter_n ? 0 : cnt + 1;
  end
  // ready rises mid-clock on purpose: only phase-one samples may count
  assign mem_ready_in = cnt >= 32 * n_waits;
  // idle bus shows the inverted word, never a stale one
  assign mem_data_in = {12'h5a0, n_waits} ^ {16{cycle_delimiter_n}};
endmodule : mem_partner
`default_nettype wire

// ### tb/board_bus_buffer_wait_control_tb_top.sv
// self-checking bench for bus_buffer_ctrl
// assumes mem_partner answers on the memory side
`timescale 1ns/1ps
`default_nettype none
`include "bus_buffer_consts.svh"
module board_bus_buffer_wait_control_tb_top;
  logic mclk = 1'h0, rst_n = 1'h0, mem_access_strobe_n = 1'h1, read_strobe = 1'h0;
  logic cycle_request = 1'h0, one_wait_jumper = 1'h0, bus_request_n = 1'h1;
  logic onboard_mem_select = 1'h0, mem_ready_in, wait_ack, cycle_delimiter_n, cycle_done;
  logic read_data_valid, bus_grant, cpu_lines_float, data_dir_offboard, addr_dir_offboard;
  logic ctrl_dir_offboard, always_out_enable, internal_io_select, bit_io_buf_enable;
  logic [3:0]  addr_upper = 4'h0, n_waits = 4'h0;
  logic [15:0] mem_data_in, read_data;
  int          n_errors = 0, n_checks = 0, cyc = 0;
  bus_buffer_ctrl u_bus_buffer_ctrl (.*);
  mem_partner u_mem_partner (.*);
  always #5 mclk = ~mclk;
  // ****
  // checks and scenarios
  // ****
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task automatic run_cycle(input logic r, o, j, input logic [3:0] w, input int x);
    int nw;
    int nd;
    nw = 0;
    nd = 0;
    {read_strobe, onboard_mem_select, one_wait_jumper, n_waits} = {r, o, j, w};
    cycle_request = 1'h1;
    mem_access_strobe_n = 1'h0;
    repeat (400) begin
      @(posedge mclk) #1;
      if (cycle_done === 1'h1) break;
      nw += wait_ack;
      nd += !cycle_delimiter_n;
    end
    chk("wait cycles", 16'(32 * x), 16'(nw));
    chk("delimiter cycles", 16'(48 + 32 * x), 16'(nd));
    if (r) chk("read data", {12'h5a0, w}, read_data);
    chk("read valid", 16'(r), 16'(read_data_valid));
    cycle_request = 1'h0;
    mem_access_strobe_n = 1'h1;
    @(posedge mclk) #1;
  endtask : run_cycle
  task automatic dir_table(input logic g);
    logic e;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk) #1;
      {onboard_mem_select, read_strobe} = 2'(i);
      e = g ? i[1] & i[0] : i[1] | !i[0];
      #1 chk("data dir", 16'(e), 16'(data_dir_offboard));
    end
  endtask : dir_table
  task automatic dma_test();
    fork
      run_cycle(1'h0, 1'h0, 1'h0, 4'h1, 1);
      begin
        repeat (40) @(posedge mclk);
        #1 bus_request_n = 1'h0;
        repeat (30) @(posedge mclk);
        #1 chk("grant mid cycle", 16'h0, 16'(bus_grant));
      end
    join
    chk("float first", 16'h2, 16'({cpu_lines_float, bus_grant}));
    repeat (2) @(posedge mclk);
    #1 chk("grant", 16'h1, 16'(bus_grant & cpu_lines_float));
    chk("dirs", 16'h0, 16'(addr_dir_offboard | ctrl_dir_offboard));
    dir_table(1'h1);
    @(posedge mclk) #1;
    cycle_request = 1'h1;
    mem_access_strobe_n = 1'h0;
    repeat (80) @(posedge mclk);
    #1 chk("refused cycle", 16'h1, 16'(cycle_delimiter_n));
    {cycle_request, mem_access_strobe_n, bus_request_n} = 3'h3;
    repeat (2) @(posedge mclk);
    #1 chk("grant off", 16'h0, 16'(bus_grant));
    dir_table(1'h0);
  endtask : dma_test
  task automatic io_test();
    logic e;
    for (int i = 0; i < 32; i++) begin
      @(posedge mclk) #1;
      {mem_access_strobe_n, addr_upper} = 5'(i);
      e = !(i[4] && i[3:0] == `IO_ONBOARD_UPPER);
      #1 chk("bit io enable", 16'(e), 16'(bit_io_buf_enable));
      chk("io select", 16'(!e), 16'(internal_io_select));
      chk("fixed enable", 16'h1, 16'(always_out_enable));
    end
  endtask : io_test
  task automatic stop_test();
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  initial begin
    repeat (5) @(posedge mclk);
    #1 rst_n = 1'h1;
    run_cycle(1'h1, 1'h0, 1'h0, 4'h0, 0);
    run_cycle(1'h0, 1'h1, 1'h0, 4'h2, 2);
    run_cycle(1'h1, 1'h1, 1'h1, 4'hf, 1);
    run_cycle(1'h1, 1'h0, 1'h0, 4'h1, 1);
    dma_test();
    io_test();
    stop_test();
  end
endmodule : board_bus_buffer_wait_control_tb_top
`default_nettype wire
